// file: logic/cwd_consts.vh
// Purpose: Shared constants for the cycle timebase window watchdog.
// Assumes: Durations are counted in internal timing cycles of 32 clocks.
// Notes:   Register offsets are byte addresses on the AXI4-Lite slave.
`ifndef CWD_CONSTS_VH
`define CWD_CONSTS_VH

// One internal timing cycle spans this many clock periods.
`define CWD_CLK_PER_CYCLE   6'h20
`define CWD_TICK_LAST       (`CWD_CLK_PER_CYCLE - 6'h01)

// Watchdog durations in internal timing cycles.
`define CWD_WD_TIMEOUT_CYL  6'h16
`define CWD_CLOSED_CYL      6'h10
`define CWD_OPEN_CYL        6'h10
`define CWD_LONG_OPEN_CYL   6'h20
`define CWD_PULSE_CYL       6'h04

// Autotiming durations in internal timing cycles.
`define CWD_AT_PERIOD_CYL   8'h80
`define CWD_AT_SHORT_CYL    8'h40
`define CWD_AT_ON_CYL       8'h02

// Register byte offsets.
`define CWD_OFS_CTRL        12'h000
`define CWD_OFS_DIAG        12'h004
`define CWD_OFS_STAT        12'h008

// Control register bit positions and reset value.
`define CWD_CTRL_TRIG       0
`define CWD_CTRL_WDCTL      1
`define CWD_CTRL_AUTO       4
`define CWD_CTRL_HSON       5
`define CWD_CTRL_RST        8'h00

// Diagnosis register bit positions.
`define CWD_DIAG_TEMP       0
`define CWD_DIAG_WDRST      1

// AXI response codes.
`define CWD_RESP_OKAY       2'h0
`define CWD_RESP_SLVERR     2'h2

`endif

// file: logic/cwd_tick.v
// Purpose: Divides the clock into one internal timing cycle strobe.
// Assumes: sys_clk is the block's oscillator clock.
// Notes:   The strobe is one clock wide, once every 32 clocks.
`timescale 1ns/1ps
`include "cwd_consts.vh"

module cwd_tick (
	// Clock and reset
	input  wire sys_clk,
	input  wire rst_b,
	// Cycle strobe
	output wire cyc_tick
);

	reg  [5:0] div_q;
	wire [5:0] div_d;

	// Free running divider; wraps at the last clock of a cycle.
	assign div_d    = (div_q == `CWD_TICK_LAST) ? 6'h00 : div_q + 6'h01;
	assign cyc_tick = (div_q == `CWD_TICK_LAST);

	// Divider register.
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			div_q <= 6'h00;
		end else begin
			div_q <= div_d;
		end
	end

endmodule // cwd_tick

// file: logic/cwd_watchdog.v
// Purpose: Window watchdog and high side autotiming with an AXI4-Lite slave.
// Assumes: Pins low_load_wd_disable, thermal_prewarn and sleep_mode are asynchronous.
// Notes:   All durations are counted in internal timing cycles from cwd_tick.
//
// What this block does
// - One internal timing cycle equals 32 oscillator periods; all durations use it.
// - Watchdog timeout period is 22 internal cycles.
// - After a service, or when the watchdog is switched back on, a 16 cycle closed window rejects service.
// - An open window of 16 cycles follows, in which service is accepted.
// - Watchdog failure drives reset output low for 4 cycles.
// - Diagnosis bit 1 reports that a watchdog reset occurred.
// - Leaving sleep with watchdog off grants a 32 cycle long open window only if the watchdog is back on within one clock.
// - Watchdog is off only with control bit 1 and low load both active.
// - Control bits 4 and 5 high switch the high side every 128 cycles.
// - Autotiming keeps the high side on for 2 cycles per period.
// - After a watchdog reset the autotiming period is shortened.
// - Diagnosis bit 0 reports the thermal prewarning.
// - High side output follows control bits 4 and 5 written by the host, and is forced off during a reset pulse.
`timescale 1ns/1ps
`include "cwd_consts.vh"

module cwd_watchdog (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        rst_b,
	// AXI4-Lite write address channel
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [11:0] s_axi_awaddr,
	// AXI4-Lite write data channel
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	// AXI4-Lite write response channel
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	output wire [1:0]  s_axi_bresp,
	// AXI4-Lite read address channel
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	input  wire [11:0] s_axi_araddr,
	// AXI4-Lite read data channel
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	// Device pins
	input  wire        low_load_wd_disable,
	input  wire        thermal_prewarn,
	input  wire        sleep_mode,
	output wire        reset_output_n,
	output wire        high_side_out
);

	// Watchdog states.
	localparam [2:0] ST_FIRST  = 3'h0;
	localparam [2:0] ST_CLOSED = 3'h1;
	localparam [2:0] ST_OPEN   = 3'h2;
	localparam [2:0] ST_LONG   = 3'h3;
	localparam [2:0] ST_PULSE  = 3'h4;
	localparam [2:0] ST_OFF    = 3'h5;

	// True on the last cycle of a window of the given length.
	function is_last;
		input [5:0] cnt;
		input [5:0] len;
		begin
			is_last = (cnt == len - 6'h01);
		end
	endfunction

	wire        cyc_tick;
	reg  [2:0]  sync1_q;
	reg  [2:0]  sync2_q;
	reg         sleep_prev_q;
	reg  [7:0]  ctrl_q;
	reg  [7:0]  ctrl_d;
	reg         wd_seen_q;
	wire        wd_seen_d;
	reg  [2:0]  st_q;
	reg  [2:0]  st_d;
	reg  [5:0]  cnt_q;
	reg  [5:0]  cnt_d;
	reg         fail;
	reg         fail_pend_q;
	reg         fail_pend_d;
	reg  [7:0]  at_cnt_q;
	reg  [7:0]  at_cnt_d;
	reg         hs_q;
	reg         hs_d;
	reg         rst_out_q;
	reg         aw_full_q;
	reg  [11:0] aw_addr_q;
	reg         w_full_q;
	reg  [31:0] w_data_q;
	reg  [3:0]  w_strb_q;
	reg         bvalid_q;
	reg  [1:0]  bresp_q;
	reg         rvalid_q;
	reg  [31:0] rdata_q;
	reg  [1:0]  rresp_q;
	wire        llwd_s;
	wire        temp_s;
	wire        sleep_s;
	wire        sleep_exit;
	wire        wd_off;
	wire        wr_fire;
	wire        ctrl_sel;
	wire        diag_sel;
	wire        wr_mapped;
	wire        service;
	wire        diag_clr;
	wire        at_en;
	wire [7:0]  at_period;
	wire        rd_fire;
	wire [31:0] rd_word;
	wire        rd_mapped;

	// Cycle strobe generator.
	cwd_tick u_tick (
		.sys_clk  (sys_clk),
		.rst_b    (rst_b),
		.cyc_tick (cyc_tick)
	);

	// Two stage synchronisers for the asynchronous pins; only stage two is read.
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_q      <= 3'h0;
			sync2_q      <= 3'h0;
			sleep_prev_q <= 1'b0;
		end else begin
			sync1_q      <= {sleep_mode, thermal_prewarn, low_load_wd_disable};
			sync2_q      <= sync1_q;
			sleep_prev_q <= sync2_q[2];
		end
	end

	assign llwd_s     = sync2_q[0];
	assign temp_s     = sync2_q[1];
	assign sleep_s    = sync2_q[2];
	assign sleep_exit = sleep_prev_q & ~sleep_s;

	// The watchdog may stop only when both conditions agree.
	assign wd_off = ctrl_q[`CWD_CTRL_WDCTL] & llwd_s;

	// Write channel: address and data are held until both have arrived.
	assign s_axi_awready = ~aw_full_q;
	assign s_axi_wready  = ~w_full_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign wr_fire       = aw_full_q & w_full_q & ~bvalid_q;
	assign ctrl_sel      = (aw_addr_q == `CWD_OFS_CTRL);
	assign diag_sel      = (aw_addr_q == `CWD_OFS_DIAG);
	assign wr_mapped     = ctrl_sel | diag_sel;

	// A service is a control write with the trigger bit set.
	assign service  = wr_fire & ctrl_sel & w_strb_q[0] & w_data_q[`CWD_CTRL_TRIG];
	assign diag_clr = wr_fire & diag_sel & w_strb_q[0] & w_data_q[`CWD_DIAG_WDRST];

	// Write channel registers.
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= 12'h000;
			w_full_q  <= 1'b0;
			w_data_q  <= 32'h00000000;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `CWD_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_full_q) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= {s_axi_awaddr[11:2], 2'h0};
			end else if (wr_fire) begin
				aw_full_q <= 1'b0;
			end
			if (s_axi_wvalid && !w_full_q) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_full_q <= 1'b0;
			end
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_mapped ? `CWD_RESP_OKAY : `CWD_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Control register; the trigger bit is a pulse and is not kept.
	always @* begin
		ctrl_d = ctrl_q;
		if (wr_fire && ctrl_sel && w_strb_q[0]) begin
			ctrl_d = w_data_q[7:0];
			ctrl_d[`CWD_CTRL_TRIG] = 1'b0;
		end
	end

	// Sticky watchdog reset flag; a new failure wins over a clear.
	assign wd_seen_d = (wd_seen_q & ~diag_clr) | fail;

	// Watchdog window sequencer.
	always @* begin
		st_d  = st_q;
		cnt_d = cyc_tick ? cnt_q + 6'h01 : cnt_q;
		fail  = 1'b0;
		fail_pend_d = fail_pend_q;
		case (st_q)
			ST_FIRST: begin
				if (wd_off) begin
					st_d  = ST_OFF;
					cnt_d = 6'h00;
				end else if (service) begin
					st_d  = ST_CLOSED;
					cnt_d = 6'h00;
				end else if (cyc_tick && is_last(cnt_q, `CWD_WD_TIMEOUT_CYL)) begin
					fail = 1'b1;
				end
			end
			ST_CLOSED: begin
				if (wd_off) begin
					st_d  = ST_OFF;
					cnt_d = 6'h00;
				end else if (service) begin
					fail_pend_d = 1'b1;
				end else if (cyc_tick && is_last(cnt_q, `CWD_CLOSED_CYL)) begin
					st_d  = ST_OPEN;
					cnt_d = 6'h00;
				end
			end
			ST_OPEN, ST_LONG: begin
				if (wd_off) begin
					st_d  = ST_OFF;
					cnt_d = 6'h00;
				end else if (service) begin
					st_d  = ST_CLOSED;
					cnt_d = 6'h00;
				end else if (cyc_tick && ((st_q == ST_OPEN) ?
						is_last(cnt_q, `CWD_OPEN_CYL) :
						is_last(cnt_q, `CWD_LONG_OPEN_CYL))) begin
					fail = 1'b1;
				end
			end
			ST_PULSE: begin
				if (cyc_tick && is_last(cnt_q, `CWD_PULSE_CYL)) begin
					st_d  = ST_FIRST;
					cnt_d = 6'h00;
				end
			end
			ST_OFF: begin
				cnt_d = 6'h00;
				if (sleep_exit) begin
					st_d = ST_LONG;
				end else if (!wd_off) begin
					st_d = ST_CLOSED;
				end
			end
			default: begin
				st_d  = ST_FIRST;
				cnt_d = 6'h00;
			end
		endcase
		// A closed window service fails at the next strobe, so the pulse keeps its full length.
		if (fail_pend_q && cyc_tick) begin
			fail = 1'b1;
		end
		if (fail) begin
			st_d  = ST_PULSE;
			cnt_d = 6'h00;
			fail_pend_d = 1'b0;
		end
	end

	// Autotiming runs while both high side bits are set.
	assign at_en     = ctrl_q[`CWD_CTRL_AUTO] & ctrl_q[`CWD_CTRL_HSON];
	assign at_period = wd_seen_q ? `CWD_AT_SHORT_CYL : `CWD_AT_PERIOD_CYL;

	// Autotiming counter and high side drive; a reset pulse forces the switch off.
	always @* begin
		at_cnt_d = at_cnt_q;
		if (!at_en) begin
			at_cnt_d = 8'h00;
		end else if (cyc_tick) begin
			if (at_cnt_q >= at_period - 8'h01) begin
				at_cnt_d = 8'h00;
			end else begin
				at_cnt_d = at_cnt_q + 8'h01;
			end
		end
		if (st_d == ST_PULSE) begin
			hs_d = 1'b0;
		end else if (at_en) begin
			hs_d = (at_cnt_d < `CWD_AT_ON_CYL);
		end else begin
			hs_d = ctrl_q[`CWD_CTRL_HSON];
		end
	end

	// State registers of the watchdog and the high side.
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q    <= `CWD_CTRL_RST;
			wd_seen_q <= 1'b0;
			fail_pend_q <= 1'b0;
			st_q      <= ST_FIRST;
			cnt_q     <= 6'h00;
			at_cnt_q  <= 8'h00;
			hs_q      <= 1'b0;
			rst_out_q <= 1'b0;
		end else begin
			ctrl_q    <= ctrl_d;
			wd_seen_q <= wd_seen_d;
			fail_pend_q <= fail_pend_d;
			st_q      <= st_d;
			cnt_q     <= cnt_d;
			at_cnt_q  <= at_cnt_d;
			hs_q      <= hs_d;
			rst_out_q <= (st_d != ST_PULSE);
		end
	end

	assign reset_output_n = rst_out_q;
	assign high_side_out  = hs_q;

	// Read channel: one read at a time, answered one cycle after acceptance.
	assign s_axi_arready = ~rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign rd_fire       = s_axi_arvalid & ~rvalid_q;
	assign rd_mapped     = (s_axi_araddr[11:2] == `CWD_OFS_CTRL >> 2) |
	                       (s_axi_araddr[11:2] == `CWD_OFS_DIAG >> 2) |
	                       (s_axi_araddr[11:2] == `CWD_OFS_STAT >> 2);

	// Read data mux; unmapped words read as zero.
	assign rd_word =
		(s_axi_araddr[11:2] == `CWD_OFS_CTRL >> 2) ? {24'h000000, ctrl_q} :
		(s_axi_araddr[11:2] == `CWD_OFS_DIAG >> 2) ?
			{30'h00000000, wd_seen_q, temp_s} :
		(s_axi_araddr[11:2] == `CWD_OFS_STAT >> 2) ?
			{18'h00000, cnt_q, 4'h0, hs_q, st_q} :
		32'h00000000;

	// Read channel registers.
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h00000000;
			rresp_q  <= `CWD_RESP_OKAY;
		end else begin
			if (rd_fire) begin
				rvalid_q <= 1'b1;
				rdata_q  <= rd_word;
				rresp_q  <= rd_mapped ? `CWD_RESP_OKAY : `CWD_RESP_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

endmodule // cwd_watchdog

// file: tb/cwd_watchdog_checker.sv
// Purpose: Port level checks on the window watchdog block.
// Assumes: One clock domain; rst_b is active low.
// Notes:   The reset pulse is counted in clocks, 4 cycles of 32.
`timescale 1ns/1ps
module cwd_watchdog_checker (
	// Clock and reset
	input wire        sys_clk,
	input wire        rst_b,
	// Write channels
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [1:0]  s_axi_bresp,
	// Read channels
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata,
	// Pins
	input wire        reset_output_n,
	input wire        high_side_out
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// Clocks the reset output has been low; one count follows every release of rst_b.
	logic [7:0] low_q;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			low_q <= 8'h00;
		else if (reset_output_n)
			low_q <= 8'h00;
		else
			low_q <= low_q + 8'h01;
	end
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence wr_commit;
		!s_axi_awready ##1 s_axi_bvalid;
	endsequence
	pulse_len_a: assert property ($rose(reset_output_n) && low_q != 8'h01 |-> low_q == 8'h80)
		else $error("reset pulse length wrong");
	hs_off_a: assert property (!reset_output_n && $past(!reset_output_n) |-> !high_side_out)
		else $error("high side on during reset pulse");
	wr_resp_a: assert property (wr_take |=> wr_commit)
		else $error("write response timing wrong");
	bresp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
		else $error("bad write response code");
	bhold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rhold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	arready_a: assert property (s_axi_arready == !s_axi_rvalid)
		else $error("read address ready wrong");
endmodule // cwd_watchdog_checker

// file: tb/cwd_host.sv
// Purpose: Host model that serves the watchdog registers over AXI4-Lite.
// Assumes: Calls start just after a clock edge.
// Notes:   One write or one read at a time; the bench timeout ends a hang.
`timescale 1ns/1ps
module cwd_host (
	// Clock
	input  wire         sys_clk,
	// Write channels
	output logic        s_axi_awvalid = 1'b0,
	input  wire         s_axi_awready,
	output logic [11:0] s_axi_awaddr = 12'h000,
	output logic        s_axi_wvalid = 1'b0,
	input  wire         s_axi_wready,
	output logic [31:0] s_axi_wdata = 32'h0,
	output logic [3:0]  s_axi_wstrb = 4'hf,
	input  wire         s_axi_bvalid,
	output logic        s_axi_bready = 1'b0,
	input  wire  [1:0]  s_axi_bresp,
	// Read channels
	output logic        s_axi_arvalid = 1'b0,
	input  wire         s_axi_arready,
	output logic [11:0] s_axi_araddr = 12'h000,
	input  wire         s_axi_rvalid,
	output logic        s_axi_rready = 1'b0,
	input  wire  [31:0] s_axi_rdata,
	input  wire  [1:0]  s_axi_rresp
);
	// The caller times services; a closed window service is only sent on purpose.
	task wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	// Read waits for the answer as long as the slave takes.
	task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule // cwd_host

// file: tb/cycle_timebase_window_watchdog_test.sv
// Purpose: Self-checking bench for the window watchdog and autotiming.
// Assumes: 4 ns clock; window edges may shift by one partial cycle.
// Notes:   Autotiming runs with the watchdog off so no pulse interferes.
`timescale 1ns/1ps
`include "cwd_consts.vh"
module cycle_timebase_window_watchdog_test;
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        low_load_wd_disable = 1'b0;
	logic        thermal_prewarn = 1'b0;
	logic        sleep_mode = 1'b0;
	wire         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	wire         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	wire         reset_output_n, high_side_out;
	wire  [11:0] s_axi_awaddr, s_axi_araddr;
	wire  [31:0] s_axi_wdata, s_axi_rdata;
	wire  [3:0]  s_axi_wstrb;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] rd_q;
	logic [1:0]  resp;
	int          n;
	int          miscompares = 0;
	int          checks = 0;
	cwd_watchdog DUT (.sys_clk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
		.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .low_load_wd_disable,
		.thermal_prewarn, .sleep_mode, .reset_output_n, .high_side_out);
	cwd_host host (.sys_clk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
		.s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
		.s_axi_rready, .s_axi_rdata, .s_axi_rresp);
	// Clock of 250 MHz.
	initial forever #2 sys_clk = ~sys_clk;
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task ok(input bit c);
		check({31'h0, c}, 32'h1);
	endtask
	task give_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Counts edges until a pin shows a level; the bound keeps a dead pin from hanging.
	task wait_pin(input bit hs, input logic v, output int cnt);
		cnt = 0;
		while ((hs ? high_side_out : reset_output_n) !== v && cnt < 8000) begin
			@(posedge sys_clk);
			cnt++;
		end
	endtask
	task stat(input logic [31:0] exp);
		host.rd(`CWD_OFS_STAT, rd_q, resp);
		check(rd_q & 32'h7, exp);
	endtask
	task at_period(input int per);
		// The first on time after enabling is cut short by the free running timebase.
		wait_pin(1'b1, 1'b1, n);
		wait_pin(1'b1, 1'b0, n);
		wait_pin(1'b1, 1'b1, n);
		wait_pin(1'b1, 1'b0, n);
		check(n, 64);
		wait_pin(1'b1, 1'b1, n);
		check(n + 64, per);
	endtask
	task t_timeout;
		// The reset output is low during rst_b, so timing starts once it has risen.
		wait_pin(1'b0, 1'b1, n);
		wait_pin(1'b0, 1'b0, n);
		ok(n >= 670 && n <= 710);
		wait_pin(1'b0, 1'b1, n);
		check(n, 128);
		host.rd(`CWD_OFS_DIAG, rd_q, resp);
		check(rd_q & 32'h2, 32'h2);
		host.wr(`CWD_OFS_DIAG, 32'h2, resp);
		host.rd(`CWD_OFS_DIAG, rd_q, resp);
		check(rd_q & 32'h2, 32'h0);
		$display("test timeout finished");
	endtask
	task t_regs;
		host.rd(`CWD_OFS_CTRL, rd_q, resp);
		check(rd_q, 32'h0);
		stat(32'h0);
		host.rd(12'h010, rd_q, resp);
		check({30'h0, resp}, 32'h2);
		host.wr(12'h010, 32'h1, resp);
		check({30'h0, resp}, 32'h2);
		$display("test registers finished");
	endtask
	task t_auto;
		low_load_wd_disable <= 1'b1;
		host.wr(`CWD_OFS_CTRL, 32'h02, resp);
		repeat (8) @(posedge sys_clk);
		stat(32'h5);
		host.wr(`CWD_OFS_CTRL, 32'h22, resp);
		repeat (4) @(posedge sys_clk);
		ok(high_side_out === 1'b1);
		host.wr(`CWD_OFS_CTRL, 32'h02, resp);
		repeat (4) @(posedge sys_clk);
		ok(high_side_out === 1'b0);
		host.wr(`CWD_OFS_CTRL, 32'h32, resp);
		at_period(4096);
		host.wr(`CWD_OFS_CTRL, 32'h00, resp);
		low_load_wd_disable <= 1'b0;
		$display("test autotiming finished");
	endtask
	task t_service;
		repeat (544) @(posedge sys_clk);
		stat(32'h2);
		host.wr(`CWD_OFS_CTRL, 32'h1, resp);
		stat(32'h1);
		host.wr(`CWD_OFS_CTRL, 32'h1, resp);
		wait_pin(1'b0, 1'b0, n);
		ok(n < 40);
		wait_pin(1'b0, 1'b1, n);
		$display("test service finished");
	endtask
	task t_expire;
		host.wr(`CWD_OFS_CTRL, 32'h1, resp);
		wait_pin(1'b0, 1'b0, n);
		ok(n >= 980 && n <= 1030);
		wait_pin(1'b0, 1'b1, n);
		$display("test expiry finished");
	endtask
	task t_long;
		low_load_wd_disable <= 1'b1;
		sleep_mode <= 1'b1;
		host.wr(`CWD_OFS_CTRL, 32'h02, resp);
		repeat (8) @(posedge sys_clk);
		// Normal mode needs the watchdog running again, so the low load indication drops too.
		sleep_mode <= 1'b0;
		low_load_wd_disable <= 1'b0;
		repeat (8) @(posedge sys_clk);
		stat(32'h3);
		host.wr(`CWD_OFS_CTRL, 32'h00, resp);
		$display("test long window finished");
	endtask
	task t_thermal;
		thermal_prewarn <= 1'b1;
		repeat (6) @(posedge sys_clk);
		host.rd(`CWD_OFS_DIAG, rd_q, resp);
		check(rd_q & 32'h1, 32'h1);
		thermal_prewarn <= 1'b0;
		repeat (6) @(posedge sys_clk);
		host.rd(`CWD_OFS_DIAG, rd_q, resp);
		check(rd_q & 32'h1, 32'h0);
		$display("test thermal finished");
	endtask
	task t_short;
		low_load_wd_disable <= 1'b1;
		host.wr(`CWD_OFS_CTRL, 32'h32, resp);
		at_period(2048);
		$display("test short period finished");
	endtask
	// Main sequence; reset spans four clocks.
	initial begin
		repeat (4) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_timeout;
		t_regs;
		t_auto;
		t_service;
		t_expire;
		t_long;
		t_thermal;
		t_short;
		give_verdict;
	end
	// Hang guard, well beyond the roughly 15k clocks the tests need.
	initial begin
		#300000;
		miscompares++;
		give_verdict;
	end
endmodule // cycle_timebase_window_watchdog_test
bind cwd_watchdog cwd_watchdog_checker chk (.sys_clk, .rst_b, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .reset_output_n,
	.high_side_out);
